/* rtl/fll_cfg_defines.svh */
// register map, field positions, reset values and timing counts of the loop control block
`ifndef FLL_CFG_DEFINES_SVH
`define FLL_CFG_DEFINES_SVH
`define IDX_INT_MULT      10'h192
`define IDX_FRAC_NUM      10'h193
`define IDX_FRAC_DEN      10'h194
`define IDX_FB_DIV        10'h195
`define IDX_REF_CTRL      10'h196
`define IDX_GAIN_CTRL     10'h198
`define IDX_MODE_CTRL     10'h19A
`define IDX_LOCK_CTRL     10'h19B
`define IDX_OSC_RANGE     10'h19D
`define IDX_STATUS        10'h1A0
`define IDX_GPIO_CFG      10'h1A1
`define RST_INT_MULT      16'h0004
`define RST_FRAC_NUM      16'h0000
`define RST_FRAC_DEN      16'h0000
`define RST_FB_DIV        16'h0001
`define RST_REF_CTRL      16'h8000
`define RST_GAIN_CTRL     16'h2100
`define RST_MODE_CTRL     16'h0000
`define RST_LOCK_CTRL     16'h0011
`define RST_OSC_RANGE     16'h0000
`define RST_GPIO_CFG      16'h0000
`define MSK_INT_MULT      16'h03FF
`define MSK_FRAC_NUM      16'hFFFF
`define MSK_FRAC_DEN      16'hFFFF
`define MSK_FB_DIV        16'h03FF
`define MSK_REF_CTRL      16'h80C0
`define MSK_GAIN_CTRL     16'hFFFF
`define MSK_MODE_CTRL     16'hC000
`define MSK_LOCK_CTRL     16'h001F
`define MSK_OSC_RANGE     16'h0003
`define MSK_GPIO_CFG      16'h0003
`define POS_REF_EN        15
`define POS_REF_DIV       6
`define POS_FD_COARSE     0
`define POS_FD_FINE       4
`define POS_MODE          14
`define POS_LOCK_EN       0
`define POS_LOCK_THR      1
`define POS_GPIO_CLK_SEL  0
`define CLK_PERIOD_NS     4
`define DEBOUNCE_NS       32
`define DEBOUNCE_CYCLES   ((`DEBOUNCE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* rtl/fll_cfg_pkg.sv */
// types shared by the loop control block
package fll_cfg_pkg;
  typedef enum logic [1:0] {
    MODE_INTEGER    = 2'b00,
    MODE_RESV_A     = 2'b01,
    MODE_RESV_B     = 2'b10,
    MODE_FRACTIONAL = 2'b11
  } loop_mode_type;
  typedef enum logic [3:0] {
    SLOT_INT_MULT  = 4'h0,
    SLOT_FRAC_NUM  = 4'h1,
    SLOT_FRAC_DEN  = 4'h2,
    SLOT_FB_DIV    = 4'h3,
    SLOT_REF_CTRL  = 4'h4,
    SLOT_GAIN_CTRL = 4'h5,
    SLOT_MODE_CTRL = 4'h6,
    SLOT_LOCK_CTRL = 4'h7,
    SLOT_OSC_RANGE = 4'h8,
    SLOT_GPIO_CFG  = 4'h9,
    SLOT_STATUS    = 4'hA,
    SLOT_NONE      = 4'hF
  } slot_type;
endpackage

/* rtl/fll_config_lock_status.sv */
// loop configuration registers, lock and reference status, debounce and gpio routing
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "fll_cfg_defines.svh"
module fll_config_lock_status (
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        ref_detect_i,
  input  wire logic        slow_clk_running_i,
  input  wire logic        system_clock_running_i,
  input  wire logic        loop_enable_i,
  input  wire logic [3:0]  freq_error_i,
  input  wire logic [3:0]  fll_clk_i,
  output logic      [9:0]  integer_multiplier_o,
  output logic      [15:0] fraction_numerator_o,
  output logic      [15:0] fraction_denominator_o,
  output logic      [9:0]  feedback_divider_o,
  output logic      [1:0]  reference_divider_o,
  output logic      [1:0]  oscillator_range_select_o,
  output logic      [3:0]  freq_detect_gain_fine_o,
  output logic signed [4:0] freq_detect_gain_log2_o,
  output logic             loop_fraction_mode_o,
  output logic             gpio_lock_o,
  output logic             gpio_clk_o,
  output logic             irq_ref_present_o,
  output logic             irq_lock_o,
  output logic             ref_stop_evt_o,
  output logic             lock_change_evt_o
);
  localparam int NCFG = 10;
  localparam logic [3:0] DEB_LAST = 4'(`DEBOUNCE_CYCLES - 1);
  localparam logic [15:0] RST_TAB [NCFG] = '{`RST_INT_MULT, `RST_FRAC_NUM, `RST_FRAC_DEN,
    `RST_FB_DIV, `RST_REF_CTRL, `RST_GAIN_CTRL, `RST_MODE_CTRL, `RST_LOCK_CTRL,
    `RST_OSC_RANGE, `RST_GPIO_CFG};
  localparam logic [15:0] MSK_TAB [NCFG] = '{`MSK_INT_MULT, `MSK_FRAC_NUM, `MSK_FRAC_DEN,
    `MSK_FB_DIV, `MSK_REF_CTRL, `MSK_GAIN_CTRL, `MSK_MODE_CTRL, `MSK_LOCK_CTRL,
    `MSK_OSC_RANGE, `MSK_GPIO_CFG};

  // bus state
  logic                 wr_pend_ff;
  logic                 nxt_wr_pend;
  fll_cfg_pkg::slot_type slot_ff;
  fll_cfg_pkg::slot_type nxt_slot;
  fll_cfg_pkg::slot_type addr_slot;
  logic [15:0]          cfg_ff [NCFG];
  logic [15:0]          nxt_cfg [NCFG];
  logic                 addr_take;

  // status state
  logic [2:0]           sync1_ff;
  logic [2:0]           sync2_ff;
  logic [2:0]           sync3_ff;
  logic [2:0]           filt_ff;
  logic [2:0]           nxt_filt;
  logic [1:0]           raw_stat;
  logic [1:0]           deb_ff;
  logic [1:0]           nxt_deb;
  logic [1:0]           flip;
  logic [3:0]           cnt_ff [2];
  logic [3:0]           nxt_cnt [2];
  logic                 ref_evt_ff;
  logic                 nxt_ref_evt;
  logic                 lock_evt_ff;
  logic                 nxt_lock_evt;
  logic                 clk_ok;
  logic                 lock_en;
  logic                 ref_en;
  logic [3:0]           lock_thr;
  logic [3:0]           coarse_code;
  logic [1:0]           mode_code;
  logic [15:0]          status_word;
  logic [15:0]          rd_word;

  function automatic fll_cfg_pkg::slot_type decode(input logic [31:0] a);
    logic [29:0] w;
    w = a[31:2];
    if (w == 30'(`IDX_INT_MULT)) return fll_cfg_pkg::SLOT_INT_MULT;
    else if (w == 30'(`IDX_FRAC_NUM)) return fll_cfg_pkg::SLOT_FRAC_NUM;
    else if (w == 30'(`IDX_FRAC_DEN)) return fll_cfg_pkg::SLOT_FRAC_DEN;
    else if (w == 30'(`IDX_FB_DIV)) return fll_cfg_pkg::SLOT_FB_DIV;
    else if (w == 30'(`IDX_REF_CTRL)) return fll_cfg_pkg::SLOT_REF_CTRL;
    else if (w == 30'(`IDX_GAIN_CTRL)) return fll_cfg_pkg::SLOT_GAIN_CTRL;
    else if (w == 30'(`IDX_MODE_CTRL)) return fll_cfg_pkg::SLOT_MODE_CTRL;
    else if (w == 30'(`IDX_LOCK_CTRL)) return fll_cfg_pkg::SLOT_LOCK_CTRL;
    else if (w == 30'(`IDX_OSC_RANGE)) return fll_cfg_pkg::SLOT_OSC_RANGE;
    else if (w == 30'(`IDX_GPIO_CFG)) return fll_cfg_pkg::SLOT_GPIO_CFG;
    else if (w == 30'(`IDX_STATUS)) return fll_cfg_pkg::SLOT_STATUS;
    else return fll_cfg_pkg::SLOT_NONE;
  endfunction

  // ahb-lite slave, zero wait states
  assign addr_take   = hsel_i && htrans_i[1] && hready_i;
  assign addr_slot   = decode(haddr_i);
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_comb begin
    nxt_wr_pend = addr_take && hwrite_i;
    nxt_slot    = addr_take ? addr_slot : fll_cfg_pkg::SLOT_NONE;
    for (int i = 0; i < NCFG; i++) begin
      nxt_cfg[i] = cfg_ff[i];
      if (wr_pend_ff && (slot_ff == fll_cfg_pkg::slot_type'(4'(i)))) begin
        nxt_cfg[i] = hwdata_i[15:0] & MSK_TAB[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_ff <= 1'b0;
      slot_ff    <= fll_cfg_pkg::SLOT_NONE;
      for (int i = 0; i < NCFG; i++) begin
        cfg_ff[i] <= RST_TAB[i];
      end
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      slot_ff    <= nxt_slot;
      for (int i = 0; i < NCFG; i++) begin
        cfg_ff[i] <= nxt_cfg[i];
      end
    end
  end

  // read mux in data phase, unmapped reads zero
  assign status_word = {10'h000, filt_ff[2:1], deb_ff, raw_stat};
  always_comb begin
    rd_word = 16'h0000;
    if (slot_ff == fll_cfg_pkg::SLOT_STATUS) begin
      rd_word = status_word;
    end else if (slot_ff != fll_cfg_pkg::SLOT_NONE) begin
      rd_word = cfg_ff[slot_ff];
    end
  end
  assign hrdata_o = {16'h0000, rd_word};

  // field outputs
  assign integer_multiplier_o      = cfg_ff[fll_cfg_pkg::SLOT_INT_MULT][9:0];
  assign fraction_numerator_o      = cfg_ff[fll_cfg_pkg::SLOT_FRAC_NUM];
  assign fraction_denominator_o    = cfg_ff[fll_cfg_pkg::SLOT_FRAC_DEN];
  assign feedback_divider_o        = cfg_ff[fll_cfg_pkg::SLOT_FB_DIV][9:0];
  assign reference_divider_o       = cfg_ff[fll_cfg_pkg::SLOT_REF_CTRL][`POS_REF_DIV +: 2];
  assign oscillator_range_select_o = cfg_ff[fll_cfg_pkg::SLOT_OSC_RANGE][1:0];
  assign freq_detect_gain_fine_o   = cfg_ff[fll_cfg_pkg::SLOT_GAIN_CTRL][`POS_FD_FINE +: 4];
  assign coarse_code = cfg_ff[fll_cfg_pkg::SLOT_GAIN_CTRL][`POS_FD_COARSE +: 4];
  assign mode_code   = cfg_ff[fll_cfg_pkg::SLOT_MODE_CTRL][`POS_MODE +: 2];
  assign lock_thr    = cfg_ff[fll_cfg_pkg::SLOT_LOCK_CTRL][`POS_LOCK_THR +: 4];
  assign lock_en     = cfg_ff[fll_cfg_pkg::SLOT_LOCK_CTRL][`POS_LOCK_EN];
  assign ref_en      = cfg_ff[fll_cfg_pkg::SLOT_REF_CTRL][`POS_REF_EN];
  // log2 of gain is minus the signed code
  assign freq_detect_gain_log2_o = 5'sd0 - $signed({coarse_code[3], coarse_code});
  // reserved codes fall back to integer behaviour
  assign loop_fraction_mode_o =
    (fll_cfg_pkg::loop_mode_type'(mode_code) == fll_cfg_pkg::MODE_FRACTIONAL);

  // raw status, combinational to gpio without any clock
  assign raw_stat[1] = lock_en && loop_enable_i &&
    (freq_error_i <= lock_thr);
  assign raw_stat[0] = ref_en && filt_ff[0];
  assign gpio_lock_o = raw_stat[1];
  assign gpio_clk_o  = fll_clk_i[cfg_ff[fll_cfg_pkg::SLOT_GPIO_CFG][`POS_GPIO_CLK_SEL +: 2]];

  // three-stage synchronisers, change taken once stages two and three agree
  always_comb begin
    nxt_filt = filt_ff;
    for (int i = 0; i < 3; i++) begin
      if (sync2_ff[i] == sync3_ff[i]) begin
        nxt_filt[i] = sync3_ff[i];
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      sync3_ff <= 3'h0;
      filt_ff  <= 3'h0;
    end else begin
      sync1_ff <= {system_clock_running_i, slow_clk_running_i, ref_detect_i};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      filt_ff  <= nxt_filt;
    end
  end
  assign clk_ok = filt_ff[1] || filt_ff[2];

  // debounce per status bit, frozen while no clock runs
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_deb
      always_comb begin
        nxt_cnt[g] = 4'h0;
        flip[g]    = 1'b0;
        nxt_deb[g] = deb_ff[g];
        if (!clk_ok) begin
          nxt_cnt[g] = cnt_ff[g];
        end else if (raw_stat[g] != deb_ff[g]) begin
          if (cnt_ff[g] == DEB_LAST) begin
            flip[g]    = 1'b1;
            nxt_deb[g] = raw_stat[g];
          end else begin
            nxt_cnt[g] = cnt_ff[g] + 4'h1;
          end
        end
      end
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          cnt_ff[g] <= 4'h0;
          deb_ff[g] <= 1'b0;
        end else begin
          cnt_ff[g] <= nxt_cnt[g];
          deb_ff[g] <= nxt_deb[g];
        end
      end
    end
  endgenerate

  // events toward the interrupt controller
  always_comb begin
    nxt_ref_evt  = flip[0] && deb_ff[0];
    nxt_lock_evt = flip[1];
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_evt_ff  <= 1'b0;
      lock_evt_ff <= 1'b0;
    end else begin
      ref_evt_ff  <= nxt_ref_evt;
      lock_evt_ff <= nxt_lock_evt;
    end
  end
  assign irq_ref_present_o = deb_ff[0];
  assign irq_lock_o        = deb_ff[1];
  assign ref_stop_evt_o    = ref_evt_ff;
  assign lock_change_evt_o = lock_evt_ff;

  // checks
  sequence s_lock_steady;
    (raw_stat[1] && clk_ok)[*8];
  endsequence
  sequence s_irq_lock_up;
    ##[0:2] irq_lock_o;
  endsequence

  property p_gain_decode;
    @(posedge core_clk_i) disable iff (rst_i)
      freq_detect_gain_log2_o == -$signed({coarse_code[3], coarse_code});
  endproperty
  a_gain_decode: assert property (p_gain_decode) else $error("gain exponent wrong");
  property p_mode;
    @(posedge core_clk_i) disable iff (rst_i)
      $changed(mode_code) |-> (loop_fraction_mode_o == (mode_code == 2'b11));
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_thr;
    @(posedge core_clk_i) disable iff (rst_i)
      (freq_error_i > lock_thr) |-> !gpio_lock_o ##1 !$rose(irq_lock_o);
  endproperty
  a_thr: assert property (p_thr) else $error("lock above threshold");
  property p_thr_only;
    @(posedge core_clk_i) disable iff (rst_i)
      $changed(lock_thr) |-> $stable(loop_fraction_mode_o) && $stable(freq_detect_gain_log2_o);
  endproperty
  a_thr_only: assert property (p_thr_only) else $error("threshold moved loop");
  property p_lock_en;
    @(posedge core_clk_i) disable iff (rst_i)
      (!lock_en && loop_enable_i && freq_error_i == 4'h0) |-> !gpio_lock_o;
  endproperty
  a_lock_en: assert property (p_lock_en) else $error("lock while disabled");
  property p_ref_en;
    @(posedge core_clk_i) disable iff (rst_i)
      (!ref_en && filt_ff[0]) |-> !raw_stat[0];
  endproperty
  a_ref_en: assert property (p_ref_en) else $error("reference while disabled");
  property p_debounce;
    @(posedge core_clk_i) disable iff (rst_i)
      s_lock_steady |=> s_irq_lock_up;
  endproperty
  a_debounce: assert property (p_debounce) else $error("debounce too slow");
  property p_no_clk;
    @(posedge core_clk_i) disable iff (rst_i)
      $changed(irq_lock_o) |-> $past(clk_ok);
  endproperty
  a_no_clk: assert property (p_no_clk) else $error("status moved without clock");
  property p_evt;
    @(posedge core_clk_i) disable iff (rst_i)
      $changed(irq_lock_o) |-> lock_change_evt_o;
  endproperty
  a_evt: assert property (p_evt) else $error("lock change not flagged");
  property p_ref_stop;
    @(posedge core_clk_i) disable iff (rst_i)
      $fell(irq_ref_present_o) |-> ref_stop_evt_o;
  endproperty
  a_ref_stop: assert property (p_ref_stop) else $error("reference stop not flagged");
  property p_loop_off;
    @(posedge core_clk_i) disable iff (rst_i)
      !loop_enable_i |-> !gpio_lock_o;
  endproperty
  a_loop_off: assert property (p_loop_off) else $error("lock while loop off");
  property p_gpio_clk;
    @(posedge core_clk_i) disable iff (rst_i)
      gpio_clk_o == fll_clk_i[cfg_ff[fll_cfg_pkg::SLOT_GPIO_CFG][1:0]];
  endproperty
  a_gpio_clk: assert property (p_gpio_clk) else $error("clock select wrong");
endmodule // fll_config_lock_status

/* verif/fll_ref_model.sv */
// partner model: reference source, loop status inputs and loop-derived clocks
`timescale 1ns/10ps
module fll_ref_model (
  input  wire logic       core_clk_i,
  input  wire logic       ref_on_i,
  input  wire logic       lock_ok_i,
  input  wire logic [3:0] err_i,
  input  wire logic [1:0] run_i,
  output logic            ref_detect_o,
  output logic            loop_enable_o,
  output logic      [3:0] freq_error_o,
  output logic      [3:0] fll_clk_o,
  output logic            slow_clk_running_o,
  output logic            system_clock_running_o
);
  logic [3:0] div_ff = 4'h0;
  always_ff @(posedge core_clk_i) begin
    div_ff <= div_ff + 4'h1;
  end
  // reference detect follows ref_on_i directly; loop clocks are the core clock divided by 2 to 16
  assign ref_detect_o = ref_on_i;
  assign loop_enable_o = lock_ok_i;
  assign freq_error_o = err_i;
  assign fll_clk_o = div_ff;
  assign slow_clk_running_o = run_i[0];
  assign system_clock_running_o = run_i[1];
endmodule // fll_ref_model

/* verif/tb.sv */
// self-checking bench of the loop control block
`timescale 1ns/10ps
`include "fll_cfg_defines.svh"
module tb;
  logic core_clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
  logic [1:0] htrans_i = 2'h0, run = 2'h3;
  logic [2:0] hsize_i = 3'h2;
  logic hreadyout_o, hresp_o, ref_detect, loop_en, gpio_lock_o, gpio_clk_o;
  logic irq_ref_present_o, irq_lock_o, ref_stop_evt_o, lock_change_evt_o;
  logic ref_on = 1'b0, lock_ok = 1'b0, slow_run, sys_run, frac_o, rd_ph_ff = 1'b0;
  logic [3:0] err = 4'h0, ferr, fclk, fine_o, thr, e;
  logic [9:0] mult_o, fbd_o;
  logic [15:0] num_o, den_o;
  logic [1:0] rdiv_o, osc_o;
  logic signed [4:0] log2_o;
  logic [31:0] rd_q[$];
  logic lk_q[$];
  int error_cnt = 0, cmp_count = 0, cyc = 0, seed = 88041, i;
  always #2 core_clk_i = ~core_clk_i;
  fll_ref_model u_model (.core_clk_i(core_clk_i), .ref_on_i(ref_on), .lock_ok_i(lock_ok),
    .err_i(err), .run_i(run), .ref_detect_o(ref_detect), .loop_enable_o(loop_en),
    .freq_error_o(ferr), .fll_clk_o(fclk), .slow_clk_running_o(slow_run),
    .system_clock_running_o(sys_run));
  fll_config_lock_status u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
    .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
    .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .ref_detect_i(ref_detect), .slow_clk_running_i(slow_run),
    .system_clock_running_i(sys_run), .loop_enable_i(loop_en), .freq_error_i(ferr),
    .fll_clk_i(fclk), .integer_multiplier_o(mult_o), .fraction_numerator_o(num_o),
    .fraction_denominator_o(den_o), .feedback_divider_o(fbd_o),
    .reference_divider_o(rdiv_o), .oscillator_range_select_o(osc_o),
    .freq_detect_gain_fine_o(fine_o), .freq_detect_gain_log2_o(log2_o),
    .loop_fraction_mode_o(frac_o), .gpio_lock_o(gpio_lock_o), .gpio_clk_o(gpio_clk_o),
    .irq_ref_present_o(irq_ref_present_o), .irq_lock_o(irq_lock_o),
    .ref_stop_evt_o(ref_stop_evt_o), .lock_change_evt_o(lock_change_evt_o));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic ahb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    @(posedge core_clk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    hsize_i <= 3'h2;
    haddr_i <= {20'h0, idx, 2'b00};
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    rd_q.push_back(exp);
    ahb(1'b0, idx, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // monitor: read data taken at the end of each data phase
  always @(posedge core_clk_i) begin
    if (rd_ph_ff && hreadyout_o && rd_q.size() > 0) check(hrdata_o, rd_q.pop_front());
    if (lock_change_evt_o === 1'b1 && lk_q.size() > 0) check(irq_lock_o, lk_q.pop_front());
    rd_ph_ff <= hsel_i & htrans_i[1] & ~hwrite_i & hreadyout_o;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(`IDX_LOCK_CTRL, 32'h11);
    rd(`IDX_MODE_CTRL, 32'h0);
    rd(`IDX_GAIN_CTRL, 32'h2100);
    rd(`IDX_OSC_RANGE, 32'h0);
    ahb(1'b1, 10'h3FF, 32'h1234);
    rd(10'h3FF, 32'h0);
    // example fractional setup: 12 MHz reference to 49.152 MHz
    ahb(1'b1, `IDX_REF_CTRL, 32'h8000);
    ahb(1'b1, `IDX_INT_MULT, 32'h018);
    ahb(1'b1, `IDX_FRAC_NUM, 32'h48);
    ahb(1'b1, `IDX_FRAC_DEN, 32'h7D);
    ahb(1'b1, `IDX_OSC_RANGE, 32'h3);
    ahb(1'b1, `IDX_MODE_CTRL, 32'hC000);
    rd(`IDX_INT_MULT, 32'h018);
    rd(`IDX_FRAC_DEN, 32'h7D);
    check({fbd_o, rdiv_o, osc_o}, {10'h001, 2'h0, 2'h3});
    check({hresp_o, fine_o, den_o}, {1'b0, 4'h0, 16'h007D});
    for (i = 0; i < 16; i++) begin
      ahb(1'b1, `IDX_GAIN_CTRL, 32'h1200 | i);
      tick(0);
      check(log2_o, -$signed({i[3], i[3:0]}));
    end
    for (i = 0; i < 4; i++) begin
      ahb(1'b1, `IDX_MODE_CTRL, i << 14);
      tick(0);
      check(frac_o, i == 3);
      rd(`IDX_MODE_CTRL, i << 14);
    end
    ahb(1'b1, `IDX_FRAC_NUM, $random(seed) & 32'hFFFF);
    tick(0);
    check(num_o, hwdata_i[15:0]);
    lock_ok <= 1'b1;
    for (i = 0; i < 10; i++) begin
      thr = $random(seed);
      e = (i == 0) ? thr : $random(seed);
      ahb(1'b1, `IDX_LOCK_CTRL, {thr, 1'b1});
      err <= e;
      tick(2);
      check(gpio_lock_o, e <= thr);
      check(mult_o, 10'h018);
    end
    ahb(1'b1, `IDX_LOCK_CTRL, 32'h1E);
    err <= 4'h0;
    tick(2);
    check(gpio_lock_o, 1'b0);
    lock_ok <= 1'b0;
    tick(20);
    ahb(1'b1, `IDX_LOCK_CTRL, 32'h11);
    tick(20);
    check(irq_lock_o, 1'b0);
    lk_q.push_back(1'b1);
    @(posedge core_clk_i);
    lock_ok <= 1'b1;
    tick(7);
    check(irq_lock_o, 1'b0);
    tick(1);
    check(irq_lock_o, 1'b1);
    run <= 2'h0;
    tick(6);
    err <= 4'hF;
    tick(2);
    check(gpio_lock_o, 1'b0);
    tick(30);
    check(irq_lock_o, 1'b1);
    lk_q.push_back(1'b0);
    run <= 2'h2;
    tick(30);
    check(irq_lock_o, 1'b0);
    ref_on <= 1'b1;
    tick(30);
    check(irq_ref_present_o, 1'b1);
    ref_on <= 1'b0;
    for (i = 0; i < 30 && ref_stop_evt_o !== 1'b1; i++) tick(1);
    check(ref_stop_evt_o, 1'b1);
    check(irq_ref_present_o, 1'b0);
    ahb(1'b1, `IDX_REF_CTRL, 32'h0);
    ref_on <= 1'b1;
    tick(30);
    check(irq_ref_present_o, 1'b0);
    rd(`IDX_STATUS, 32'h20);
    for (i = 0; i < 4; i++) begin
      ahb(1'b1, `IDX_GPIO_CFG, i);
      repeat (3) begin
        tick(1);
        check(gpio_clk_o, fclk[i]);
      end
    end
    check(lk_q.size() + rd_q.size(), 0);
    final_report();
  end
endmodule // tb
